// [src/rsq_defines.svh]
// constants for the regulator enable sequencer
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

`define RSQ_STATUS_ADDR     8'h0F
`define RSQ_CFG_ADDR        8'h12
`define RSQ_CFG_RESET       8'h00
`define RSQ_FIRST_LSB       0
`define RSQ_SECOND_LSB      4
`define RSQ_CODE_W          3
`define RSQ_PIN_STS_BIT     0
`define RSQ_CLK_PERIOD_NS   10
`define RSQ_MS_NS           1000000
`define RSQ_MS_CYCLES       (`RSQ_MS_NS / `RSQ_CLK_PERIOD_NS)
`define RSQ_DLY_SEL0_MS     8'h50
`define RSQ_DLY_SEL1_MS     8'h78
`define RSQ_DLY_SEL2_MS     8'hA0
`define RSQ_DLY_SEL3_MS     8'hC8
`define RSQ_DLY_STEP_MS     4
`define RSQ_BUS_EN_OFF      2'h0

`endif

// [src/rsq_pkg.sv]
// types shared by the regulator enable sequencer
package rsq_pkg;

   typedef enum logic [2:0] {
      CODE_OFF      = 3'b000,
      CODE_RESERVED = 3'b001,
      CODE_AT_0     = 3'b010,
      CODE_AT_25    = 3'b011,
      CODE_AT_50    = 3'b100,
      CODE_PIN_LOW  = 3'b101,
      CODE_PIN_HIGH = 3'b110,
      CODE_BUS      = 3'b111
   } seq_code_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_COUNT = 2'b01,
      ST_DONE  = 2'b10
   } seq_state_t;

endpackage

// [src/regulator_channel.sv]
// per-regulator decode of a sequencing code into an enable
`timescale 1ns/1ns
`include "rsq_defines.svh"
module regulator_channel
   import rsq_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic [2:0] i_code,
   input  wire logic       i_pin_level,
   input  wire logic [1:0] i_bus_enable,
   input  wire logic       i_at_0,
   input  wire logic       i_at_25,
   input  wire logic       i_at_50,
   input  wire logic       i_at_100,
   output logic            o_enable_ff
);

   logic nxt_enable;

   always_comb
   begin
      case (seq_code_t'(i_code))
         CODE_OFF:      nxt_enable = 1'b0;
         CODE_RESERVED: nxt_enable = 1'b0;
         CODE_AT_0:     nxt_enable = i_at_0;
         CODE_AT_25:    nxt_enable = i_at_25;
         CODE_AT_50:    nxt_enable = i_at_50;
         CODE_PIN_LOW:  nxt_enable = ~i_pin_level;
         CODE_PIN_HIGH: nxt_enable = i_pin_level;
         CODE_BUS:      nxt_enable = i_at_100 &
                                     (i_bus_enable != `RSQ_BUS_EN_OFF);
         default:       nxt_enable = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_enable_ff <= 1'b0;
      else
         o_enable_ff <= nxt_enable;
   end

endmodule // regulator_channel

// [src/regulator_enable_sequencer.sv]
// power-on enable sequencing for two linear regulators
// Function
// - code 000 off; 001 reserved, off
// - 010/011/100 enable at 0/25/50% delay
// - 101 pin active low, 110 active high
// - first regulator 111: bus enable after delay
// - second regulator decoded alike, own bus field
// - config bits 6:4 and 2:0, read-only
// - boot delay select gives 80/120/160/200 ms
// - control pin level readable as status bit
`timescale 1ns/1ns
`include "rsq_defines.svh"
module regulator_enable_sequencer
   import rsq_pkg::*;
#(
   parameter int MS_CYCLES = `RSQ_MS_CYCLES
)
(
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic [7:0] i_sequence_config_strap,
   input  wire logic [1:0] i_boot_delay_select,
   input  wire logic       i_multi_purpose_control_pin,
   input  wire logic [1:0] i_first_regulator_bus_enable,
   input  wire logic [1:0] i_second_regulator_bus_enable,
   input  wire logic       i_rd_en,
   input  wire logic [7:0] i_rd_addr,
   output logic            o_first_regulator_enable_ff,
   output logic            o_second_regulator_enable_ff,
   output logic            o_sequence_done_ff,
   output logic [7:0]      o_rd_data_ff,
   output logic            o_rd_valid_ff
);

   if (MS_CYCLES < 1)
   begin : g_bad_ms
      $error("MS_CYCLES must be at least one");
   end

   // the quarter and half thresholds are shifts of the whole delay, so
   // every delay must divide into four whole milliseconds
   if (((`RSQ_DLY_SEL0_MS % `RSQ_DLY_STEP_MS) != 0) ||
       ((`RSQ_DLY_SEL1_MS % `RSQ_DLY_STEP_MS) != 0) ||
       ((`RSQ_DLY_SEL2_MS % `RSQ_DLY_STEP_MS) != 0) ||
       ((`RSQ_DLY_SEL3_MS % `RSQ_DLY_STEP_MS) != 0))
   begin : g_bad_delay
      $error("boot delays must be whole multiples of four ms");
   end

   localparam int TW = $clog2(MS_CYCLES + 1);

   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic [TW-1:0] tick_cnt_ff;
   logic [7:0]    ms_cnt_ff;
   logic [7:0]    regulator_sequence_config_ff;
   logic [7:0]    delay_ms_ff;
   logic          captured_ff;

   wire logic        ms_tick;
   wire logic [7:0]  sel_delay_ms;
   wire logic [7:0]  thr_25;
   wire logic [7:0]  thr_50;
   wire logic        at_0;
   wire logic        at_25;
   wire logic        at_50;
   wire logic        at_100;
   wire logic        delay_end;
   wire logic [2:0]  code [2];
   wire logic [1:0]  bus_en [2];
   wire logic [7:0]  cfg_view;
   wire logic [7:0]  status_view;
   wire logic [7:0]  rd_mux;

   assign sel_delay_ms = (i_boot_delay_select == 2'h0) ? `RSQ_DLY_SEL0_MS :
                         (i_boot_delay_select == 2'h1) ? `RSQ_DLY_SEL1_MS :
                         (i_boot_delay_select == 2'h2) ? `RSQ_DLY_SEL2_MS :
                                                         `RSQ_DLY_SEL3_MS;

   // all delays are multiples of 4 ms, so the shifts are exact
   assign thr_25 = delay_ms_ff >> 2;
   assign thr_50 = delay_ms_ff >> 1;

   // the divider runs only while counting, so every boot starts at zero
   assign ms_tick = (state_ff == ST_COUNT) &&
                    (tick_cnt_ff == TW'(MS_CYCLES - 1));

   // the last tick of the last millisecond ends the delay
   assign delay_end = ms_tick && ((ms_cnt_ff + 8'h01) >= delay_ms_ff);

   // pin codes bypass these; only the timed and bus codes wait here
   assign at_0   = (state_ff != ST_IDLE);
   assign at_25  = at_0 && (ms_cnt_ff >= thr_25);
   assign at_50  = at_0 && (ms_cnt_ff >= thr_50);
   assign at_100 = (state_ff == ST_DONE);

   assign code[0] = regulator_sequence_config_ff[`RSQ_FIRST_LSB +: `RSQ_CODE_W];
   assign code[1] = regulator_sequence_config_ff[`RSQ_SECOND_LSB +:
                                                 `RSQ_CODE_W];
   assign bus_en[0] = i_first_regulator_bus_enable;
   assign bus_en[1] = i_second_regulator_bus_enable;

   assign cfg_view = {1'b0,
                      regulator_sequence_config_ff[`RSQ_SECOND_LSB +:
                                                   `RSQ_CODE_W],
                      1'b0,
                      regulator_sequence_config_ff[`RSQ_FIRST_LSB +:
                                                   `RSQ_CODE_W]};
   assign status_view = {7'h00, i_multi_purpose_control_pin};

   // unmapped addresses answer zero with valid; nothing here is writable
   assign rd_mux = (i_rd_addr == `RSQ_CFG_ADDR)    ? cfg_view    :
                   (i_rd_addr == `RSQ_STATUS_ADDR) ? status_view :
                                                     8'h00;

   always_comb
   begin
      case (state_ff)
         ST_IDLE:  nxt_state = captured_ff ? ST_COUNT : ST_IDLE;
         ST_COUNT: nxt_state = delay_end ? ST_DONE : ST_COUNT;
         ST_DONE:  nxt_state = ST_DONE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   // straps are caught on the first edge after reset release; later
   // changes on them are ignored until the next reset
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         captured_ff <= 1'b0;
      else
         captured_ff <= 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         regulator_sequence_config_ff <= `RSQ_CFG_RESET;
         delay_ms_ff                  <= `RSQ_DLY_SEL0_MS;
      end
      else if (!captured_ff)
      begin
         regulator_sequence_config_ff <= i_sequence_config_strap;
         delay_ms_ff                  <= sel_delay_ms;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // one-ms enable pulse divider
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         tick_cnt_ff <= '0;
      else if (state_ff == ST_COUNT)
         tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + TW'(1);
   end

   // the single delay counter that every threshold compares against
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         ms_cnt_ff <= 8'h00;
      else if (ms_tick)
         ms_cnt_ff <= ms_cnt_ff + 8'h01;
   end

   // read data idle at zero so a stray sample never shows stale bits
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_rd_data_ff  <= 8'h00;
         o_rd_valid_ff <= 1'b0;
      end
      else
      begin
         o_rd_data_ff  <= i_rd_en ? rd_mux : 8'h00;
         o_rd_valid_ff <= i_rd_en;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_sequence_done_ff <= 1'b0;
      else
         o_sequence_done_ff <= at_100;
   end

   logic [1:0] enable_ff;

   // one decoder per regulator; both share the thresholds and the pin
   for (genvar g = 0; g < 2; g++)
   begin : g_chan
      regulator_channel u_chan (
         .i_clk        (i_clk),
         .i_arst_n     (i_arst_n),
         .i_code       (code[g]),
         .i_pin_level  (i_multi_purpose_control_pin),
         .i_bus_enable (bus_en[g]),
         .i_at_0       (at_0),
         .i_at_25      (at_25),
         .i_at_50      (at_50),
         .i_at_100     (at_100),
         .o_enable_ff  (enable_ff[g])
      );
   end

   assign o_first_regulator_enable_ff  = enable_ff[0];
   assign o_second_regulator_enable_ff = enable_ff[1];

endmodule // regulator_enable_sequencer

// [bench/regulator_enable_sequencer_properties.sv]
// port checker for the regulator enable sequencer
`timescale 1ns/1ns
module regulator_enable_sequencer_properties
(
   input wire logic       i_clk,
   input wire logic       i_arst_n,
   input wire logic [7:0] i_sequence_config_strap,
   input wire logic [1:0] i_boot_delay_select,
   input wire logic       i_multi_purpose_control_pin,
   input wire logic [1:0] i_first_regulator_bus_enable,
   input wire logic [1:0] i_second_regulator_bus_enable,
   input wire logic       i_rd_en,
   input wire logic [7:0] i_rd_addr,
   input wire logic       o_first_regulator_enable_ff,
   input wire logic       o_second_regulator_enable_ff,
   input wire logic       o_sequence_done_ff,
   input wire logic [7:0] o_rd_data_ff,
   input wire logic       o_rd_valid_ff
);
   // straps land one edge after release, so the off, pin and config checks wait 3 edges
   logic [1:0] age_ff;
   wire  [2:0] c1 = i_sequence_config_strap[2:0];
   wire  [2:0] c2 = i_sequence_config_strap[6:4];
   wire        pin = i_multi_purpose_control_pin;
   wire        e1 = o_first_regulator_enable_ff;
   wire        e2 = o_second_regulator_enable_ff;
   wire        dn = o_sequence_done_ff;
   wire        up = (age_ff == 2'h3);
   always_ff @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n) age_ff <= 2'h0;
      else if (!up) age_ff <= age_ff + 2'h1;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_idle_data_zero: assert property (!i_rd_en |=>
      !o_rd_valid_ff && o_rd_data_ff == 8'h00) else $error("idle read");
   a_config_read_layout: assert property (up && i_rd_en &&
      i_rd_addr == 8'h12 |=> o_rd_data_ff ==
      (i_sequence_config_strap & 8'h77)) else $error("config read");
   a_status_pin_level: assert property (i_rd_en &&
      i_rd_addr == 8'h0F |=> o_rd_data_ff == {7'h00, $past(pin)})
      else $error("status read");
   a_off_codes_hold: assert property (up && c1[2:1] == 2'h0 |=>
      !e1) else $error("off code enabled");
   a_pin_high_follow: assert property (up && c1 == 3'h6 |=>
      e1 == $past(pin)) else $error("high pin code");
   a_pin_low_follow: assert property (up && c2 == 3'h5 |=>
      e2 == !$past(pin)) else $error("low pin code");
   a_bus_wait_done: assert property (c1 == 3'h7 && !dn |=>
      !e1 || dn) else $error("bus code early");
   a_bus_after_done: assert property (dn && c2 == 3'h7 |=>
      e2 == ($past(i_second_regulator_bus_enable) != 2'h0))
      else $error("bus code follow");
endmodule // regulator_enable_sequencer_properties

bind regulator_enable_sequencer regulator_enable_sequencer_properties
   u_props (.*);

// [bench/regulator_enable_sequencer_tb_top.sv]
// self-checking bench for the regulator enable sequencer
`timescale 1ns/1ns
module regulator_enable_sequencer_tb_top;
   localparam int M = 4;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [1:0] dly = 2'h0;
   logic       pin = 1'b0;
   logic [1:0] b1 = 2'h0;
   logic [1:0] b2 = 2'h0;
   logic       rde = 1'b0;
   logic [7:0] ra = 8'h00;
   logic [7:0] rd;
   logic       e1, e2, dn, rv;
   int         cyc, t1, t2, td, tot;
   int         mismatches = 0;
   int         num_checks = 0;
   always #5 clk = ~clk;
   regulator_enable_sequencer #(.MS_CYCLES(M)) dut
   (
      .i_clk(clk), .i_arst_n(arst_n), .i_sequence_config_strap(cfg),
      .i_boot_delay_select(dly), .i_multi_purpose_control_pin(pin),
      .i_first_regulator_bus_enable(b1),
      .i_second_regulator_bus_enable(b2),
      .i_rd_en(rde), .i_rd_addr(ra),
      .o_first_regulator_enable_ff(e1),
      .o_second_regulator_enable_ff(e2),
      .o_sequence_done_ff(dn), .o_rd_data_ff(rd), .o_rd_valid_ff(rv)
   );
   // first-rise cycle of each enable and of done, counted from reset release
   always @(posedge clk)
   begin
      tot++;
      if (tot == 6000)
      begin
         mismatches++;
         summarize();
      end
      if (!arst_n) {cyc, t1, t2, td} = '0;
      else
      begin
         cyc++;
         if (e1 && t1 == 0) t1 = cyc;
         if (e2 && t2 == 0) t2 = cyc;
         if (dn && td == 0) td = cyc;
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      num_checks++;
      if (g !== x)
      begin
         mismatches++;
         $display("Error %0t: got %0h want %0h", $time, g, x);
      end
   endtask
   // a few cycles of slack cover strap capture and output registers
   task automatic win(input int t, input int lo);
      chk(8'(t >= lo && t <= lo + 6), 8'h01);
   endtask
   task automatic boot(input logic [7:0] c, input logic [1:0] d,
                       input int n);
      arst_n <= 1'b0;
      cfg <= c;
      dly <= d;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (n) @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
      rde <= 1'b1;
      ra <= a;
      @(posedge clk);
      rde <= 1'b0;
      @(posedge clk);
      chk({7'h00, rv}, 8'h01);
      chk(rd, x);
   endtask
   task automatic timed_run();
      boot(8'hBA, 2'h0, 340);
      win(t1, 1);
      win(t2, 80);
      win(td, 320);
      rd_chk(8'h12, 8'h32);
      rd_chk(8'h55, 8'h00);
   endtask
   task automatic pin_follow();
      boot(8'h56, 2'h0, 3);
      for (int i = 0; i < 4; i++)
      begin
         pin <= i[0];
         repeat (2) @(posedge clk);
         chk({6'h00, e2, e1}, {6'h00, ~i[0], i[0]});
         rd_chk(8'h0F, {7'h00, i[0]});
      end
   endtask
   task automatic half_and_bus();
      b2 <= 2'h2;
      boot(8'h74, 2'h3, 810);
      win(t1, 400);
      win(t2, 800);
      win(td, 800);
      b2 <= 2'h0;
      repeat (2) @(posedge clk);
      chk({7'h00, e2}, 8'h00);
   endtask
   task automatic bus_or_off(input logic [7:0] c, input logic [1:0] d,
                             input int ms, input logic on);
      b1 <= 2'h1;
      b2 <= 2'h3;
      boot(c, d, ms * M + 10);
      win(td, ms * M);
      chk(8'(t2), 8'h00);
      if (on) win(t1, ms * M);
      else chk(8'(t1), 8'h00);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      timed_run();
      pin_follow();
      half_and_bus();
      bus_or_off(8'h17, 2'h1, 120, 1'b1);
      bus_or_off(8'h10, 2'h2, 160, 1'b0);
      summarize();
   end
endmodule // regulator_enable_sequencer_tb_top
